/* ethtx_top.sv */
// transmit status path: data fifo accounting, status fifo, errors, stop/start
// Operation
// RULE1 - one status word pushed per packet
// RULE2 - full status fifo suspends transmission unless discarding
// RULE3 - discard mode keeps sending, drops new status
// RULE4 - after discard overrun used count reads zero
// RULE5 - status overrun errors only without discard mode
// RULE6 - status event keeps working in discard mode
// RULE7 - status bits 31:16 carry packet tag
// RULE8 - bit 15 ORs bits 11,10,9,8,2,1
// RULE9 - bit 11 carrier lost, bit 10 no carrier
// RULE10 - bit 9 late collision abort
// RULE11 - bit 8 abort after sixteen collisions
// RULE12 - bits 6:3 collision count
// RULE13 - bit 2 excessive deferral when checking enabled
// RULE14 - bit 0 packet was deferred
// RULE15 - command A always stored, B on first segment
// RULE16 - whole offset dwords stripped, partial kept
// RULE17 - whole padding dwords stripped, partial kept
// RULE18 - length mismatch flags error, transmitter continues
// RULE19 - command B must match across buffers
// RULE20 - host data fifo overrun flags error
// RULE21 - stop finishes frame, clears bits, pulses halt
// RULE22 - after halt, enable resumes pending frames
// RULE23 - reserved status bits read zero
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ethtx_top (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	// register port
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O,
	// word stream to the transmitter
	output logic [31:0] MAC_WORD_O,
	output logic MAC_WORD_VALID_O,
	input wire logic MAC_WORD_READY_I,
	// per packet completion from the transmitter
	input wire logic MAC_DONE_I,
	input wire logic MAC_LOSS_CARRIER_I,
	input wire logic MAC_NO_CARRIER_I,
	input wire logic MAC_LATE_COLL_I,
	input wire logic MAC_EXC_COLL_I,
	input wire logic [3:0] MAC_COLL_COUNT_I,
	input wire logic MAC_EXC_DEFER_I,
	input wire logic MAC_DEFERRED_I,
	// event outputs
	output logic TX_ERROR_O,
	output logic TX_HALTED_O,
	output logic TX_STATUS_EVENT_O
);
	ethtx_fifo_if #(.W(32), .AW(ethtx_pkg::STAT_AW)) sf ();
	ethtx_fifo_if #(.W(32), .AW(ethtx_pkg::DATA_AW)) df ();

	ethtx_fifo #(.W(32), .AW(ethtx_pkg::STAT_AW)) u_stat_fifo (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.f(sf.store)
	);
	ethtx_fifo #(.W(32), .AW(ethtx_pkg::DATA_AW)) u_data_fifo (
		.clk_i(REF_CLK_I),
		.rst_n_i(RESETN_I),
		.f(df.store)
	);

	// control and status state
	logic cfg_enable;
	logic cfg_stop;
	logic status_discard_overrun_enable;
	logic cfg_defer_chk;
	logic transmit_error_flag;
	logic transmit_halted_event;
	logic ovr_hold;
	logic tx_busy;
	logic feed_open;
	logic [15:0] tx_tag;

	// register decode
	wire wr_cfg = REG_WR_I && (REG_ADDR_I == ethtx_pkg::OFS_CONFIG);
	wire wr_evt = REG_WR_I && (REG_ADDR_I == ethtx_pkg::OFS_EVENTS);
	wire wr_data = REG_WR_I && (REG_ADDR_I == ethtx_pkg::OFS_DATA);
	wire rd_pop = REG_RD_I && (REG_ADDR_I == ethtx_pkg::OFS_STAT_POP);
	wire rd_peek = REG_RD_I && (REG_ADDR_I == ethtx_pkg::OFS_STAT_PEEK);
	wire rd_cfg = REG_RD_I && (REG_ADDR_I == ethtx_pkg::OFS_CONFIG);
	wire rd_info = REG_RD_I && (REG_ADDR_I == ethtx_pkg::OFS_FIFO_INFO);
	wire rd_evt = REG_RD_I && (REG_ADDR_I == ethtx_pkg::OFS_EVENTS);
	wire stat_popped = rd_pop && !sf.empty;

	// ingress: host words parsed into command A, command B and payload
	ethtx_pkg::ethtx_phase_t in_phase;
	logic [10:0] in_widx;
	logic [10:0] in_host_words;
	logic [10:0] in_first;
	logic [10:0] in_last;
	logic in_fs;
	logic in_ls;
	logic in_empty;
	logic [31:0] pkt_cmd_b;
	logic [10:0] pkt_bytes;
	wire [10:0] ca_size;
	wire [10:0] ca_host_words;
	wire [10:0] ca_first;
	wire [10:0] ca_last;
	wire [10:0] ca_stored;
	wire ca_fs;
	wire ca_ls;
	ethtx_buf_calc u_in_calc (
		.cmd_a_i(REG_WDATA_I),
		.size_o(ca_size),
		.host_words_o(ca_host_words),
		.first_word_o(ca_first),
		.last_word_o(ca_last),
		.stored_words_o(ca_stored),
		.first_seg_o(ca_fs),
		.last_seg_o(ca_ls)
	);

	// which host words reach the fifo
	wire in_is_a = (in_phase == ethtx_pkg::ETHTX_CMDA);
	wire in_is_b = (in_phase == ethtx_pkg::ETHTX_CMDB);
	wire in_kept_data = !in_empty && (in_widx >= in_first) && (in_widx <= in_last);
	wire in_keep = in_is_a || (in_is_b && in_fs) || (!in_is_a && !in_is_b && in_kept_data); // see RULE15
	wire data_overrun = wr_data && in_keep && df.full; // see RULE20
	wire [10:0] pkt_bytes_now = (in_is_a && ca_fs) ? ca_size : (pkt_bytes + ca_size);
	wire b_mismatch = wr_data && in_is_b && !in_fs && (REG_WDATA_I != pkt_cmd_b); // see RULE19
	wire [31:0] ref_b = in_fs ? REG_WDATA_I : pkt_cmd_b;
	wire len_mismatch = wr_data && in_is_b && in_ls && (pkt_bytes != ref_b[ethtx_pkg::CMDB_LEN_LSB +: 11]); // see RULE18
	assign df.push = wr_data && in_keep;
	assign df.wdata = REG_WDATA_I;
	assign df.clear = wr_cfg && REG_WDATA_I[ethtx_pkg::CFG_PURGE_DATA];

	// ingress parser; the host sends command B for every buffer even when unstored
	always_ff @(posedge REF_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			in_phase <= ethtx_pkg::ETHTX_CMDA;
			in_widx <= 11'h000;
			in_host_words <= 11'h000;
			in_first <= 11'h000;
			in_last <= 11'h000;
			in_fs <= 1'b0;
			in_ls <= 1'b0;
			in_empty <= 1'b1;
			pkt_cmd_b <= 32'h0000_0000;
			pkt_bytes <= 11'h000;
		end
		else if (wr_data)
		begin
			unique case (in_phase)
				ethtx_pkg::ETHTX_CMDA:
				begin
					in_host_words <= ca_host_words;
					in_first <= ca_first;
					in_last <= ca_last;
					in_fs <= ca_fs;
					in_ls <= ca_ls;
					in_empty <= (ca_stored == 11'h000);
					pkt_bytes <= pkt_bytes_now;
					in_phase <= ethtx_pkg::ETHTX_CMDB;
				end
				ethtx_pkg::ETHTX_CMDB:
				begin
					if (in_fs)
						pkt_cmd_b <= REG_WDATA_I;
					in_widx <= 11'h000;
					in_phase <= (in_host_words == 11'h000) ? ethtx_pkg::ETHTX_CMDA : ethtx_pkg::ETHTX_DATA;
				end
				ethtx_pkg::ETHTX_DATA:
				begin
					in_widx <= in_widx + 11'h001;
					if (in_widx + 11'h001 >= in_host_words)
						in_phase <= ethtx_pkg::ETHTX_CMDA;
				end
				default:
					in_phase <= ethtx_pkg::ETHTX_CMDA;
			endcase
		end
	end

	// egress: words leave the data fifo toward the transmitter
	ethtx_pkg::ethtx_phase_t out_phase;
	logic [10:0] out_left;
	logic out_ls;
	wire [10:0] co_stored;
	wire co_fs;
	wire co_ls;
	ethtx_buf_calc u_out_calc (
		.cmd_a_i(df.rdata),
		.size_o(),
		.host_words_o(),
		.first_word_o(),
		.last_word_o(),
		.stored_words_o(co_stored),
		.first_seg_o(co_fs),
		.last_seg_o(co_ls)
	);
	wire stat_full_stall = sf.full && !status_discard_overrun_enable; // see RULE2
	// a new packet starts only when enabled, not stopping and not stalled on status
	wire new_pkt_ok = cfg_enable && !cfg_stop && !stat_full_stall && !tx_busy; // see RULE22
	wire out_at_a = (out_phase == ethtx_pkg::ETHTX_CMDA);
	wire out_gate = !out_at_a || feed_open || new_pkt_ok;
	wire out_slot = !MAC_WORD_VALID_O || MAC_WORD_READY_I;
	wire out_take = out_slot && !df.empty && out_gate;
	wire buf_done_after_a = (co_stored == 11'h000) && !co_fs;
	assign df.pop = out_take;

	// egress parser and output register; a held word waits for ready
	always_ff @(posedge REF_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			out_phase <= ethtx_pkg::ETHTX_CMDA;
			out_left <= 11'h000;
			out_ls <= 1'b0;
			feed_open <= 1'b0;
			tx_tag <= 16'h0000;
			MAC_WORD_O <= 32'h0000_0000;
			MAC_WORD_VALID_O <= 1'b0;
		end
		else if (df.clear)
		begin
			out_phase <= ethtx_pkg::ETHTX_CMDA;
			feed_open <= 1'b0;
			MAC_WORD_VALID_O <= 1'b0;
		end
		else
		begin
			if (out_take)
			begin
				MAC_WORD_O <= df.rdata;
				MAC_WORD_VALID_O <= 1'b1;
			end
			else if (MAC_WORD_READY_I)
				MAC_WORD_VALID_O <= 1'b0;
			if (out_take)
			begin
				unique case (out_phase)
					ethtx_pkg::ETHTX_CMDA:
					begin
						out_left <= co_stored;
						out_ls <= co_ls;
						feed_open <= !(buf_done_after_a && co_ls);
						if (co_fs)
							out_phase <= ethtx_pkg::ETHTX_CMDB;
						else if (co_stored != 11'h000)
							out_phase <= ethtx_pkg::ETHTX_DATA;
					end
					ethtx_pkg::ETHTX_CMDB:
					begin
						tx_tag <= df.rdata[ethtx_pkg::TAG_LSB +: 16]; // see RULE7
						if (out_left != 11'h000)
							out_phase <= ethtx_pkg::ETHTX_DATA;
						else
						begin
							out_phase <= ethtx_pkg::ETHTX_CMDA;
							feed_open <= !out_ls;
						end
					end
					ethtx_pkg::ETHTX_DATA:
					begin
						out_left <= out_left - 11'h001;
						if (out_left == 11'h001)
						begin
							out_phase <= ethtx_pkg::ETHTX_CMDA;
							feed_open <= !out_ls;
						end
					end
					default:
						out_phase <= ethtx_pkg::ETHTX_CMDA;
				endcase
			end
		end
	end

	// status word assembly; reserved bits are forced to zero
	wire st_exc_defer = MAC_EXC_DEFER_I && cfg_defer_chk; // see RULE13
	wire st_es = MAC_LOSS_CARRIER_I | MAC_NO_CARRIER_I | MAC_LATE_COLL_I | MAC_EXC_COLL_I
		| st_exc_defer | 1'b0; // see RULE8
	wire [31:0] status_word = {
		tx_tag, // see RULE7
		st_es,
		3'b000, // see RULE23
		MAC_LOSS_CARRIER_I, // see RULE9
		MAC_NO_CARRIER_I,
		MAC_LATE_COLL_I, // see RULE10
		MAC_EXC_COLL_I, // see RULE11
		1'b0,
		MAC_COLL_COUNT_I, // see RULE12
		st_exc_defer,
		1'b0,
		MAC_DEFERRED_I // see RULE14
	};
	// a completion with a full store either drops (discard mode) or is an error
	wire stat_overrun = MAC_DONE_I && sf.full;
	assign sf.push = MAC_DONE_I && !sf.full && !ovr_hold; // see RULE1
	assign sf.wdata = status_word;
	assign sf.pop = stat_popped;
	assign sf.clear = wr_cfg && REG_WDATA_I[ethtx_pkg::CFG_PURGE_STAT];
	wire stat_err = stat_overrun && !status_discard_overrun_enable; // see RULE5
	wire any_err = stat_err || data_overrun || b_mismatch || len_mismatch;
	wire halt_now = cfg_stop && !tx_busy && !feed_open && out_at_a; // see RULE21
	localparam int STAT_W = ethtx_pkg::STAT_AW;
	wire [STAT_W:0] status_used_count = ovr_hold ? '0 : sf.count; // see RULE4

	// packet in flight, overrun hold and status event pulse
	always_ff @(posedge REF_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			tx_busy <= 1'b0;
			ovr_hold <= 1'b0;
			TX_STATUS_EVENT_O <= 1'b0;
		end
		else
		begin
			if (out_take && out_at_a && co_fs)
				tx_busy <= 1'b1;
			else if (MAC_DONE_I)
				tx_busy <= 1'b0;
			// drop further status until the host frees a slot
			if (stat_overrun && status_discard_overrun_enable)
				ovr_hold <= 1'b1; // see RULE3
			else if (stat_popped || sf.clear)
				ovr_hold <= 1'b0;
			TX_STATUS_EVENT_O <= MAC_DONE_I; // see RULE6
		end
	end

	// configuration; the halt clears enable and stop ahead of a host write
	always_ff @(posedge REF_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			{cfg_defer_chk, status_discard_overrun_enable, cfg_stop, cfg_enable} <= ethtx_pkg::CFG_RESET;
			TX_HALTED_O <= 1'b0;
		end
		else
		begin
			if (wr_cfg)
			begin
				cfg_enable <= REG_WDATA_I[ethtx_pkg::CFG_ENABLE];
				cfg_stop <= REG_WDATA_I[ethtx_pkg::CFG_STOP];
				status_discard_overrun_enable <= REG_WDATA_I[ethtx_pkg::CFG_DISCARD];
				cfg_defer_chk <= REG_WDATA_I[ethtx_pkg::CFG_DEFER_CHK];
			end
			if (halt_now)
			begin
				cfg_enable <= 1'b0; // see RULE21
				cfg_stop <= 1'b0;
			end
			TX_HALTED_O <= halt_now;
		end
	end

	// sticky event flags, write one to clear, a new event wins over the clear
	always_ff @(posedge REF_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			transmit_error_flag <= 1'b0;
			transmit_halted_event <= 1'b0;
			TX_ERROR_O <= 1'b0;
		end
		else
		begin
			transmit_error_flag <= any_err || (transmit_error_flag
				&& !(wr_evt && REG_WDATA_I[ethtx_pkg::EVT_TXERR])); // see RULE18
			transmit_halted_event <= halt_now || (transmit_halted_event
				&& !(wr_evt && REG_WDATA_I[ethtx_pkg::EVT_HALTED]));
			TX_ERROR_O <= any_err || (transmit_error_flag
				&& !(wr_evt && REG_WDATA_I[ethtx_pkg::EVT_TXERR]));
		end
	end

	// read mux; unmapped addresses and an empty status store read zero
	wire [31:0] rd_stat = sf.empty ? 32'h0000_0000 : sf.rdata;
	wire [31:0] rd_cfg_w = {28'h000_0000, cfg_defer_chk, status_discard_overrun_enable,
		cfg_stop, cfg_enable};
	wire [31:0] rd_info_w = {11'h000, status_used_count, 6'h00,
		(ethtx_pkg::DATA_AW+1)'(df.count)};
	wire [31:0] rd_evt_w = {30'h0000_0000, transmit_halted_event, transmit_error_flag};
	wire [31:0] next_rdata = (rd_pop || rd_peek) ? rd_stat :
		rd_cfg ? rd_cfg_w :
		rd_info ? rd_info_w :
		rd_evt ? rd_evt_w : 32'h0000_0000;

	// read data stands for the one cycle after the strobe
	always_ff @(posedge REF_CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			REG_RDATA_O <= 32'h0000_0000;
		else
			REG_RDATA_O <= next_rdata;
	end
endmodule // ethtx_top
`default_nettype wire

/* ethtx_pkg.sv */
// constants, register map and state types of the transmit status path
package ethtx_pkg;
	// register offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_STAT_POP = 8'h04;
	localparam logic [7:0] OFS_STAT_PEEK = 8'h08;
	localparam logic [7:0] OFS_FIFO_INFO = 8'h0C;
	localparam logic [7:0] OFS_EVENTS = 8'h10;
	localparam logic [7:0] OFS_DATA = 8'h20;
	// configuration bits
	localparam int CFG_ENABLE = 0;
	localparam int CFG_STOP = 1;
	localparam int CFG_DISCARD = 2;
	localparam int CFG_DEFER_CHK = 3;
	localparam int CFG_PURGE_STAT = 14;
	localparam int CFG_PURGE_DATA = 15;
	localparam logic [3:0] CFG_RESET = 4'h0;
	// event bits
	localparam int EVT_TXERR = 0;
	localparam int EVT_HALTED = 1;
	// command A fields
	localparam int CMDA_SIZE_LSB = 0;
	localparam int CMDA_LS = 12;
	localparam int CMDA_FS = 13;
	localparam int CMDA_OFS_LSB = 16;
	localparam int CMDA_ALIGN_LSB = 24;
	// command B / status fields
	localparam int CMDB_LEN_LSB = 0;
	localparam int TAG_LSB = 16;
	// fifo geometry
	localparam int STAT_AW = 4;
	localparam int DATA_AW = 9;
	// ingress and egress parser states
	typedef enum logic [1:0] {
		ETHTX_CMDA = 2'b00,
		ETHTX_CMDB = 2'b01,
		ETHTX_DATA = 2'b10
	} ethtx_phase_t;
endpackage

/* ethtx_fifo_if.sv */
// push/pop carrier between the path controller and its fifos
`timescale 1ns/10ps
`default_nettype none
interface ethtx_fifo_if #(parameter int W = 32, parameter int AW = 4);
	logic push;
	logic pop;
	logic clear;
	logic [W-1:0] wdata;
	logic [W-1:0] rdata;
	logic full;
	logic empty;
	logic [AW:0] count;
	modport owner (output push, pop, clear, wdata, input rdata, full, empty, count);
	modport store (input push, pop, clear, wdata, output rdata, full, empty, count);
endinterface
`default_nettype wire

/* ethtx_fifo.sv */
// synchronous first-word-fall-through fifo used for status and data
`timescale 1ns/10ps
`default_nettype none
module ethtx_fifo #(
	parameter int W = 32,
	parameter int AW = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	ethtx_fifo_if.store f
);
	logic [W-1:0] mem [0:(1<<AW)-1];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire do_push = f.push && !f.full;
	wire do_pop = f.pop && !f.empty;
	assign f.count = wr_ptr - rd_ptr;
	assign f.full = (f.count == (AW+1)'(1 << AW));
	assign f.empty = (wr_ptr == rd_ptr);
	assign f.rdata = mem[rd_ptr[AW-1:0]];
	// pointers; clear empties the store without touching the array
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else if (f.clear)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
	// storage array, no reset needed
	always_ff @(posedge clk_i)
	begin
		if (do_push)
			mem[wr_ptr[AW-1:0]] <= f.wdata;
	end
endmodule // ethtx_fifo
`default_nettype wire

/* ethtx_buf_calc.sv */
// decodes a command A word into the dword span that the data fifo keeps
`timescale 1ns/10ps
`default_nettype none
module ethtx_buf_calc (
	input wire logic [31:0] cmd_a_i,
	output logic [10:0] size_o,
	output logic [10:0] host_words_o,
	output logic [10:0] first_word_o,
	output logic [10:0] last_word_o,
	output logic [10:0] stored_words_o,
	output logic first_seg_o,
	output logic last_seg_o
);
	wire [4:0] ofs = cmd_a_i[ethtx_pkg::CMDA_OFS_LSB +: 5];
	wire [1:0] align = cmd_a_i[ethtx_pkg::CMDA_ALIGN_LSB +: 2];
	wire [12:0] end_b = {2'b00, size_o} + {8'h00, ofs};
	wire [12:0] amask = (align == 2'b10) ? 13'h001F : (align == 2'b01) ? 13'h000F : 13'h0003;
	wire [12:0] rounded = (end_b + amask) & ~amask;
	wire [12:0] last_b = end_b - 13'h0001;
	assign size_o = cmd_a_i[ethtx_pkg::CMDA_SIZE_LSB +: 11];
	assign first_seg_o = cmd_a_i[ethtx_pkg::CMDA_FS];
	assign last_seg_o = cmd_a_i[ethtx_pkg::CMDA_LS];
	assign host_words_o = rounded[12:2];
	// whole offset dwords and whole padding dwords fall outside this span
	assign first_word_o = {8'h00, ofs[4:2]}; // see RULE16
	assign last_word_o = last_b[12:2]; // see RULE17
	assign stored_words_o = (size_o == 11'h000) ? 11'h000 : (last_word_o - first_word_o + 11'h001);
endmodule // ethtx_buf_calc
`default_nettype wire

/* ethtx_mac_model.sv */
// behavioural transmitter that consumes the word stream and reports per packet
`timescale 1ns/10ps
`default_nettype none
module ethtx_mac_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// word stream from the path
	input wire logic [31:0] word_i,
	input wire logic valid_i,
	output logic ready_o,
	// completion report, st_i is {coll[3:0], loss, nocar, late, exc, exdef, defer}
	input wire logic slow_i,
	input wire logic [9:0] st_i,
	output logic done_o,
	output logic [9:0] st_o
);
	logic [1:0] ph;
	logic [10:0] left;
	logic last;
	logic tick;
	// kept dwords of one buffer: partial offset and padding stay, whole ones are gone
	wire [10:0] span = ({9'h000, word_i[17:16]} + word_i[10:0] + 11'h003) >> 2;
	wire take = valid_i && ready_o;
	// a slow far end only accepts every other cycle
	assign ready_o = slow_i ? tick : 1'b1;
	// report lines are only valid with done, so show the inverse otherwise
	assign st_o = done_o ? st_i : ~st_i;
	// cmd A, cmd B only on first segment, then data; done once per packet
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ph <= 2'h0;
			left <= 11'h000;
			last <= 1'b0;
			tick <= 1'b0;
			done_o <= 1'b0;
		end
		else
		begin
			tick <= ~tick;
			done_o <= 1'b0;
			if (take && ph == 2'h0)
			begin
				left <= span;
				last <= word_i[ethtx_pkg::CMDA_LS];
				ph <= word_i[ethtx_pkg::CMDA_FS] ? 2'h1 : 2'h2;
			end
			else if (take && ph == 2'h1)
				ph <= 2'h2;
			else if (take && ph == 2'h2)
			begin
				left <= left - 11'h001;
				if (left == 11'h001)
				begin
					ph <= 2'h0;
					done_o <= last;
				end
			end
		end
	end
endmodule // ethtx_mac_model
`default_nettype wire

/* ethtx_top_checker.sv */
// concurrent checks on the ports of the transmit status path
`timescale 1ns/10ps
`default_nettype none
module ethtx_top_checker (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RESETN_I,
	// register port
	input wire logic [7:0] REG_ADDR_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [31:0] REG_RDATA_O,
	// transmitter side
	input wire logic [31:0] MAC_WORD_O,
	input wire logic MAC_WORD_VALID_O,
	input wire logic MAC_WORD_READY_I,
	input wire logic MAC_DONE_I,
	// events
	input wire logic TX_ERROR_O,
	input wire logic TX_HALTED_O,
	input wire logic TX_STATUS_EVENT_O
);
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	// decoded strobes that the properties share
	wire clr_evt = REG_WR_I && REG_ADDR_I == ethtx_pkg::OFS_EVENTS;
	wire rd_stat = REG_RD_I && (REG_ADDR_I == ethtx_pkg::OFS_STAT_POP ||
		REG_ADDR_I == ethtx_pkg::OFS_STAT_PEEK);
	a_event_after_done: assert property (MAC_DONE_I |=> TX_STATUS_EVENT_O)
		else $error("status event missing after done");
	a_event_has_cause: assert property (TX_STATUS_EVENT_O |-> $past(MAC_DONE_I))
		else $error("status event without done");
	a_halt_one_cycle: assert property (TX_HALTED_O |=> !TX_HALTED_O)
		else $error("halt pulse longer than one cycle");
	// the flag copy is registered with the flag, so a clear drops it one cycle later; the check asks for three quiet cycles
	a_error_stays_set: assert property ((!clr_evt)[*3] ##0 TX_ERROR_O |=> TX_ERROR_O)
		else $error("error flag dropped without a clear");
	a_word_holds: assert property (MAC_WORD_VALID_O && !MAC_WORD_READY_I |=>
		MAC_WORD_VALID_O && $stable(MAC_WORD_O))
		else $error("word changed before it was taken");
	a_rdata_idle_zero: assert property (!REG_RD_I |=> REG_RDATA_O == 32'h00000000)
		else $error("read data not zero without a read");
	a_status_reserved: assert property (rd_stat |=> REG_RDATA_O[14:12] == 3'h0 &&
		!REG_RDATA_O[7] && !REG_RDATA_O[1])
		else $error("reserved status bits not zero");
	a_error_summary: assert property (rd_stat |=> REG_RDATA_O[15] ==
		|{REG_RDATA_O[11:8], REG_RDATA_O[2], REG_RDATA_O[1]})
		else $error("summary bit does not match status");
endmodule // ethtx_top_checker
bind ethtx_top ethtx_top_checker u_chk (.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I),
	.REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
	.REG_RDATA_O(REG_RDATA_O), .MAC_WORD_O(MAC_WORD_O), .MAC_WORD_VALID_O(MAC_WORD_VALID_O),
	.MAC_WORD_READY_I(MAC_WORD_READY_I), .MAC_DONE_I(MAC_DONE_I), .TX_ERROR_O(TX_ERROR_O),
	.TX_HALTED_O(TX_HALTED_O), .TX_STATUS_EVENT_O(TX_STATUS_EVENT_O));
`default_nettype wire

/* tb_ethtx_top.sv */
// self-checking bench for the transmit status path
`timescale 1ns/10ps
`default_nettype none
module tb_ethtx_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_d = 1'b0;
	logic slow = 1'b0;
	logic [9:0] st = 10'h000;
	logic [9:0] st_o;
	logic [31:0] rdata;
	logic [31:0] word;
	logic valid, ready, done, err, halted, sev;
	logic [15:0] lfsr = 16'h0014;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int error_cnt = 0;
	int samples_checked = 0;
	int cycles = 0;
	int dones = 0;
	int halts = 0;
	int nd = 0;
	// design and a transmitter model on its far side
	ethtx_top DUT (.REF_CLK_I(clk), .RESETN_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .MAC_WORD_O(word),
		.MAC_WORD_VALID_O(valid), .MAC_WORD_READY_I(ready), .MAC_DONE_I(done),
		.MAC_LOSS_CARRIER_I(st_o[5]), .MAC_NO_CARRIER_I(st_o[4]), .MAC_LATE_COLL_I(st_o[3]),
		.MAC_EXC_COLL_I(st_o[2]), .MAC_COLL_COUNT_I(st_o[9:6]), .MAC_EXC_DEFER_I(st_o[1]),
		.MAC_DEFERRED_I(st_o[0]), .TX_ERROR_O(err), .TX_HALTED_O(halted),
		.TX_STATUS_EVENT_O(sev));
	ethtx_mac_model u_mac (.clk_i(clk), .rst_n_i(rst_n), .word_i(word), .valid_i(valid),
		.ready_o(ready), .slow_i(slow), .st_i(st), .done_o(done), .st_o(st_o));
	always #5 clk = ~clk;
	// count completions and halts; a hang past the ceiling ends the run
	always @(posedge clk)
	begin
		cycles++;
		if (done)
			dones++;
		if (halted)
			halts++;
		if (cycles == 20000)
		begin
			error_cnt++;
			$display("wrong value at %0t: run did not finish", $time);
			finish_test();
		end
	end
	// read data stands only in the cycle after the strobe
	always @(posedge clk)
	begin
		if (rd_d)
			check_rd();
		rd_d <= rd;
	end
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// expected status word from tag and report flags
	function automatic logic [31:0] stat_exp(input logic [15:0] tag, input logic [9:0] f);
		return {tag, |f[5:1], 3'h0, f[5:2], 1'b0, f[9:6], f[1], 1'b0, f[0]};
	endfunction
	task automatic check_rd;
		logic [31:0] e, m;
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		samples_checked++;
		if ((rdata & m) !== (e & m))
		begin
			error_cnt++;
			$display("wrong value at %0t: read %h expected %h", $time, rdata, e);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// one buffer packet: offset of five bytes, end aligned to four, random payload
	task automatic send_pkt(input logic [15:0] tag, input logic [10:0] len,
		input logic [10:0] blen);
		int n;
		n = (5 + int'(len) + 3) / 4;
		reg_wr(ethtx_pkg::OFS_DATA, {8'h00, 3'h0, 5'h05, 2'h0, 2'h3, 1'b0, len});
		reg_wr(ethtx_pkg::OFS_DATA, {tag, 5'h00, blen});
		repeat (n)
		begin
			lfsr = lfsr_next(lfsr);
			reg_wr(ethtx_pkg::OFS_DATA, {lfsr, lfsr});
		end
	endtask
	task automatic wait_for(ref int c, input int n);
		int k;
		k = 0;
		while (c < n && k < 600)
		begin
			@(posedge clk);
			k++;
		end
		if (c < n)
		begin
			error_cnt++;
			$display("wrong value at %0t: event did not come", $time);
		end
	endtask
	task automatic finish_test;
		$display("mismatches %0d, comparisons %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// main sequence
	initial
	begin
		logic [15:0] tg;
		logic [9:0] fl;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		reg_wr(ethtx_pkg::OFS_CONFIG, 32'h00000009);
		// random flags and tags, far end sometimes slow
		for (int i = 0; i < 6; i++)
		begin
			lfsr = lfsr_next(lfsr);
			tg = lfsr;
			fl = lfsr[9:0];
			st <= fl;
			slow <= lfsr[10];
			send_pkt(tg, 11'h014 + 11'(i), 11'h014 + 11'(i));
			wait_for(dones, ++nd);
			reg_rd(ethtx_pkg::OFS_STAT_POP, stat_exp(tg, fl),
				fl[2] ? 32'hFFFFFF87 : 32'hFFFFFFFF);
		end
		// length mismatch flags an error yet the packet still completes
		st <= 10'h000;
		send_pkt(16'h00AA, 11'h010, 11'h011);
		wait_for(dones, ++nd);
		reg_rd(ethtx_pkg::OFS_EVENTS, 32'h00000001, 32'h00000001);
		reg_rd(ethtx_pkg::OFS_STAT_POP, 32'h00AA0000, 32'hFFFF0000);
		reg_wr(ethtx_pkg::OFS_EVENTS, 32'h00000001);
		reg_rd(ethtx_pkg::OFS_EVENTS, 32'h00000000, 32'h00000001);
		// fill the status fifo, then one more packet must wait
		for (int i = 0; i < 16; i++)
		begin
			send_pkt(16'h0100 + 16'(i), 11'h008, 11'h008);
			wait_for(dones, ++nd);
		end
		send_pkt(16'h01FF, 11'h008, 11'h008);
		repeat (100) @(posedge clk);
		reg_rd(ethtx_pkg::OFS_EVENTS, 32'h00000000, 32'h00000001);
		reg_rd(ethtx_pkg::OFS_STAT_POP, 32'h01000000, 32'hFFFF0000);
		wait_for(dones, ++nd);
		reg_rd(ethtx_pkg::OFS_FIFO_INFO, 32'h00100000, 32'h001F0000);
		// discard mode: keeps sending, drops status, no error
		reg_wr(ethtx_pkg::OFS_CONFIG, 32'h0000000D);
		send_pkt(16'h0200, 11'h008, 11'h008);
		wait_for(dones, ++nd);
		reg_rd(ethtx_pkg::OFS_FIFO_INFO, 32'h00000000, 32'h001F0000);
		reg_rd(ethtx_pkg::OFS_EVENTS, 32'h00000000, 32'h00000001);
		reg_rd(ethtx_pkg::OFS_STAT_PEEK, 32'h01010000, 32'hFFFF0000);
		// stop request: halt pulse, stop and enable cleared
		reg_wr(ethtx_pkg::OFS_CONFIG, 32'h0000000F);
		wait_for(halts, 1);
		reg_rd(ethtx_pkg::OFS_CONFIG, 32'h0000000C, 32'h0000000F);
		reg_rd(ethtx_pkg::OFS_EVENTS, 32'h00000002, 32'h00000002);
		// a packet queued while halted goes out after purge of status and enable
		send_pkt(16'h0300, 11'h00C, 11'h00C);
		repeat (50) @(posedge clk);
		reg_wr(ethtx_pkg::OFS_CONFIG, 32'h00004009);
		wait_for(dones, ++nd);
		reg_rd(ethtx_pkg::OFS_STAT_POP, 32'h03000000, 32'hFFFF0000);
		reg_rd(8'h40, 32'h00000000, 32'hFFFFFFFF);
		// no deferral check, two buffers whose command B words differ
		reg_wr(ethtx_pkg::OFS_CONFIG, 32'h00000001);
		st <= 10'h002;
		reg_wr(ethtx_pkg::OFS_DATA, 32'h00002004);
		reg_wr(ethtx_pkg::OFS_DATA, 32'h05000008);
		reg_wr(ethtx_pkg::OFS_DATA, 32'h11111111);
		reg_wr(ethtx_pkg::OFS_DATA, 32'h00001004);
		reg_wr(ethtx_pkg::OFS_DATA, 32'h05010008);
		reg_wr(ethtx_pkg::OFS_DATA, 32'h22222222);
		wait_for(dones, ++nd);
		reg_rd(ethtx_pkg::OFS_EVENTS, 32'h00000001, 32'h00000001);
		reg_rd(ethtx_pkg::OFS_STAT_POP, 32'h05000000, 32'hFFFF8007);
		// overfill the data fifo with the transmitter off
		reg_wr(ethtx_pkg::OFS_CONFIG, 32'h00008000);
		reg_wr(ethtx_pkg::OFS_EVENTS, 32'h00000003);
		send_pkt(16'h0400, 11'h7D0, 11'h7D0);
		send_pkt(16'h0401, 11'h028, 11'h028);
		reg_rd(ethtx_pkg::OFS_EVENTS, 32'h00000001, 32'h00000001);
		repeat (4) @(posedge clk);
		finish_test();
	end
endmodule // tb_ethtx_top
`default_nettype wire
